/* File: ssu_pkg.sv */
package ssu_pkg;
	// clock and timer step
	localparam int unsigned CLK_PERIOD_NS         = 4;
	localparam int unsigned TICK_TIME_NS          = 50000;
	localparam int unsigned TICK_CYC              = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// fixed sequence times
	localparam int unsigned CHECK_OUTPUT_DELAY_NS = 4000;
	localparam int unsigned CHECK_DLY_CYC         = (CHECK_OUTPUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned POST_TEST_SETTLE_NS   = 5000;
	localparam int unsigned SETTLE_CYC            = (POST_TEST_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// supply supervision times
	localparam int unsigned LOCKOUT_ENABLE_NS     = 64000;
	localparam int unsigned LOCK_EN_CYC           = (LOCKOUT_ENABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LOCKOUT_DISABLE_NS    = 64000;
	localparam int unsigned LOCK_DIS_CYC          = (LOCKOUT_DISABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned POR_RELEASE_NS        = 64000;
	localparam int unsigned POR_REL_CYC           = (POR_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// counter widths
	localparam int unsigned CNT_W                 = 20;
	localparam int unsigned TICK_W                = 16;
	localparam int unsigned DLY_W                 = 11;
	localparam int unsigned START_W               = 12;
	localparam int unsigned SHORT_W               = 8;
	// register map (byte addresses)
	localparam logic [11:0] ADDR_START_WAIT       = 12'h000;
	localparam logic [11:0] ADDR_FAULT_REQ        = 12'h004;
	localparam logic [11:0] ADDR_PULSE_WIDTH      = 12'h008;
	localparam logic [11:0] ADDR_STATUS           = 12'h00C;
	// reset values, in 50 us steps
	localparam logic [START_W-1:0] START_WAIT_RST = 12'h014;
	localparam logic [SHORT_W-1:0] FAULT_REQ_RST  = 8'h14;
	localparam logic [SHORT_W-1:0] PULSE_RST      = 8'h14;
	// status field positions
	localparam int unsigned STAT_PWR_LSB          = 0;
	localparam int unsigned STAT_ST_LSB           = 4;
	localparam int unsigned STAT_OUT_LSB          = 8;
	localparam int unsigned STAT_DRV_BIT          = 12;
	// output stage modes
	localparam logic [2:0] OUT_HIZ                = 3'h0;
	localparam logic [2:0] OUT_FOLLOW             = 3'h1;
	localparam logic [2:0] OUT_CHECK_LOW          = 3'h2;
	localparam logic [2:0] OUT_CHECK_HIGH         = 3'h3;
	localparam logic [2:0] OUT_SAT_TOP            = 3'h4;
	localparam logic [2:0] OUT_SAT_BOTTOM         = 3'h5;
	localparam logic [2:0] OUT_QUIESCENT          = 3'h6;
	localparam logic [2:0] OUT_GROUND             = 3'h7;
	// supply supervisor states
	typedef enum logic [2:0] {
		PWR_OFF, PWR_POR, PWR_WAKE, PWR_ON, PWR_LOCKWAIT, PWR_LOCKED, PWR_UNLOCK
	} ssu_pwr_t;
	// self-test states
	typedef enum logic [2:0] {
		ST_IDLE, ST_START, ST_CHECK, ST_POS, ST_GAP, ST_NEG, ST_SETTLE
	} ssu_st_t;
endpackage : ssu_pkg

/* File: ssu_top.sv */
// Notes on behaviour
// R1 - line pulled low starts self-test counter
// R2 - field over threshold restarts start counter
// R3 - start wait done: low level, check
// R4 - check output follows fault line level
// R5 - check output changes after propagation delay
// R6 - check state has no time limit
// R7 - line high for request time: fault test
// R8 - controller keeps line released in fault test
// R9 - positive stimulus, pull line on crossing
// R10 - after pulse width remove positive stimulus
// R11 - after gap, negative stimulus, pull line
// R12 - negative pulse done: settle, then exit
// R13 - bus transaction abandons any self-test
// R14 - start ignored during bus transaction
// R15 - supply below lower lockout leaves self-test
// R16 - output high impedance, release counter starts
// R17 - high impedance until upper lockout, delay
// R18 - lockout after enable delay, else normal
// R19 - leave lockout after disable delay
// R20 - below lower reset threshold: high impedance
// R21 - start wait spans 0.05 to 200 ms
// R22 - fault request spans 0.05 to 10 ms
// R23 - times are configuration, converted to cycles
//
// Added by the designer: the register addresses and the APB interface to the registers.
module ssu_top
	import ssu_pkg::*;
#(
	parameter int unsigned TICK_CYCLES     = TICK_CYC,
	parameter int unsigned LOCK_EN_CYCLES  = LOCK_EN_CYC,
	parameter int unsigned LOCK_DIS_CYCLES = LOCK_DIS_CYC,
	parameter int unsigned POR_REL_CYCLES  = POR_REL_CYC
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// supply comparators
	input  wire logic        supply_above_por_upper,
	input  wire logic        supply_above_por_lower,
	input  wire logic        supply_above_lockout_upper,
	input  wire logic        supply_above_lockout_lower,
	// signal path comparators
	input  wire logic        field_over_fault,
	input  wire logic        output_over_fault,
	// open-drain fault line
	input  wire logic        fault_pin_i,
	output logic             fault_pin_o,
	output logic             fault_pin_oe_b,
	// output stage mode
	output logic      [2:0]  out_mode
);

	localparam logic [TICK_W-1:0] TICK_LAST   = TICK_W'(TICK_CYCLES - 1);
	localparam logic [CNT_W-1:0]  EN_LAST     = CNT_W'(LOCK_EN_CYCLES - 1);
	localparam logic [CNT_W-1:0]  DIS_LAST    = CNT_W'(LOCK_DIS_CYCLES - 1);
	localparam logic [CNT_W-1:0]  REL_LAST    = CNT_W'(POR_REL_CYCLES - 1);
	localparam logic [DLY_W-1:0]  CHECK_LAST  = DLY_W'(CHECK_DLY_CYC - 1);
	localparam logic [DLY_W-1:0]  SETTLE_LAST = DLY_W'(SETTLE_CYC - 1);

	logic [6:0]         sync1_q;
	logic [6:0]         sync2_q;
	logic               por_up;
	logic               por_low;
	logic               lock_up;
	logic               lock_low;
	logic               field_over;
	logic               out_over;
	logic               line_high;
	ssu_pwr_t           pwr_q;
	logic [CNT_W-1:0]   pwr_cnt_q;
	ssu_st_t            st_q;
	logic [TICK_W-1:0]  presc_q;
	logic [START_W-1:0] tick_cnt_q;
	logic [DLY_W-1:0]   dly_q;
	logic               shown_hi_q;
	logic [2:0]         own_q;
	logic [START_W-1:0] start_wait_q;
	logic [SHORT_W-1:0] fault_req_q;
	logic [SHORT_W-1:0] pulse_q;
	logic               pwr_on;
	logic               abort;
	logic               tick;
	logic               apb_setup;
	logic               apb_write;
	logic               mapped;
	logic [31:0]        rd_data;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	// two-stage synchronisers for all asynchronous comparator inputs
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_q <= 7'h00;
			sync2_q <= 7'h00;
		end else begin
			sync1_q <= {supply_above_por_upper, supply_above_por_lower, supply_above_lockout_upper,
				supply_above_lockout_lower, field_over_fault, output_over_fault, fault_pin_i};
			sync2_q <= sync1_q;
		end
	end

	assign {por_up, por_low, lock_up, lock_low, field_over, out_over, line_high} = sync2_q;
	assign pwr_on = (pwr_q == PWR_ON);
	assign tick   = (presc_q == TICK_LAST);
	assign abort  = (st_q != ST_IDLE) && (psel || !pwr_on); // R13 R15

	// supply supervisor: power-on release and undervoltage lockout
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pwr_q     <= PWR_OFF;
			pwr_cnt_q <= '0;
		end else if (!por_low && pwr_q != PWR_OFF) begin
			pwr_q     <= PWR_OFF; // R20
			pwr_cnt_q <= '0;
		end else begin
			unique case (pwr_q)
				PWR_OFF: begin
					pwr_cnt_q <= '0;
					if (por_up) begin
						pwr_q <= PWR_POR; // R16
					end
				end
				PWR_POR: begin
					if (pwr_cnt_q != REL_LAST) begin
						pwr_cnt_q <= pwr_cnt_q + 1'b1; // R16
					end else if (lock_up) begin
						pwr_q     <= PWR_WAKE; // R17
						pwr_cnt_q <= '0;
					end
				end
				PWR_WAKE, PWR_UNLOCK: begin
					if (pwr_cnt_q == DIS_LAST) begin
						pwr_q     <= PWR_ON; // R17 R19
						pwr_cnt_q <= '0;
					end else begin
						pwr_cnt_q <= pwr_cnt_q + 1'b1;
					end
				end
				PWR_ON: begin
					pwr_cnt_q <= '0;
					if (!lock_low) begin
						pwr_q <= PWR_LOCKWAIT; // R18
					end
				end
				PWR_LOCKWAIT: begin
					if (lock_low) begin
						pwr_q     <= PWR_ON; // R18
						pwr_cnt_q <= '0;
					end else if (pwr_cnt_q == EN_LAST) begin
						pwr_q     <= PWR_LOCKED; // R18
						pwr_cnt_q <= '0;
					end else begin
						pwr_cnt_q <= pwr_cnt_q + 1'b1;
					end
				end
				PWR_LOCKED: begin
					pwr_cnt_q <= '0;
					if (lock_up) begin
						pwr_q <= PWR_UNLOCK; // R19
					end
				end
			endcase
		end
	end

	// self-test sequencer with 50 us tick timer and short cycle counter
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_q       <= ST_IDLE;
			presc_q    <= '0;
			tick_cnt_q <= '0;
			dly_q      <= '0;
			shown_hi_q <= 1'b0;
		end else if (abort) begin
			st_q       <= ST_IDLE; // R13 R15
			presc_q    <= '0;
			tick_cnt_q <= '0;
			dly_q      <= '0;
			shown_hi_q <= 1'b0;
		end else begin
			presc_q <= tick ? '0 : presc_q + 1'b1;
			if (tick) begin
				tick_cnt_q <= tick_cnt_q + 1'b1;
			end
			unique case (st_q)
				ST_IDLE: begin
					presc_q    <= '0;
					tick_cnt_q <= '0;
					// own drive and its echo must be gone before a start counts
					if (!line_high && fault_pin_oe_b && own_q == 3'h0 && !psel && pwr_on) begin
						st_q <= ST_START; // R1 R14
					end
				end
				ST_START: begin
					if (field_over) begin
						presc_q    <= '0; // R2
						tick_cnt_q <= '0;
					end else if (tick_cnt_q >= start_wait_q) begin
						st_q       <= ST_CHECK; // R3
						shown_hi_q <= 1'b0;
						dly_q      <= '0;
						presc_q    <= '0;
						tick_cnt_q <= '0;
					end
				end
				ST_CHECK: begin
					// shown level trails the line by the propagation delay
					if (line_high != shown_hi_q) begin
						if (dly_q == CHECK_LAST) begin
							shown_hi_q <= line_high; // R4 R5
							dly_q      <= '0;
						end else begin
							dly_q <= dly_q + 1'b1; // R5
						end
					end else begin
						dly_q <= '0;
					end
					if (!line_high) begin
						presc_q    <= '0; // R6
						tick_cnt_q <= '0;
					end else if (tick_cnt_q >= START_W'(fault_req_q)) begin
						st_q       <= ST_POS; // R7
						presc_q    <= '0;
						tick_cnt_q <= '0;
					end
				end
				ST_POS, ST_GAP, ST_NEG: begin
					if (tick_cnt_q >= START_W'(pulse_q)) begin
						presc_q    <= '0;
						tick_cnt_q <= '0;
						dly_q      <= '0;
						unique case (st_q)
							ST_POS:  st_q <= ST_GAP; // R10
							ST_GAP:  st_q <= ST_NEG; // R11
							default: st_q <= ST_SETTLE; // R12
						endcase
					end
				end
				ST_SETTLE: begin
					if (dly_q == SETTLE_LAST) begin
						st_q <= ST_IDLE; // R12
					end else begin
						dly_q <= dly_q + 1'b1;
					end
				end
			endcase
		end
	end

	// fault line pull-down: stimulus crossings, or over-field in normal use
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			fault_pin_oe_b <= 1'b1;
			fault_pin_o    <= 1'b0;
			own_q          <= 3'h0;
		end else begin
			fault_pin_oe_b <= !((((st_q == ST_POS) || (st_q == ST_NEG)) && out_over) || // R9 R11
				((st_q == ST_IDLE) && pwr_on && field_over));
			fault_pin_o    <= 1'b0;
			own_q          <= {own_q[1:0], !fault_pin_oe_b};
		end
	end

	// output stage mode from supply and self-test state
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			out_mode <= OUT_HIZ;
		end else if (pwr_q == PWR_OFF || pwr_q == PWR_POR || pwr_q == PWR_WAKE) begin
			out_mode <= OUT_HIZ; // R16 R17 R20
		end else if (pwr_q == PWR_LOCKED || pwr_q == PWR_UNLOCK) begin
			out_mode <= OUT_GROUND; // R18 R19
		end else begin
			unique case (st_q)
				ST_IDLE, ST_START: out_mode <= OUT_FOLLOW; // R2
				ST_CHECK:          out_mode <= shown_hi_q ? OUT_CHECK_HIGH : OUT_CHECK_LOW; // R3 R4
				ST_POS:            out_mode <= OUT_SAT_TOP; // R9
				ST_NEG:            out_mode <= OUT_SAT_BOTTOM; // R11
				ST_GAP, ST_SETTLE: out_mode <= OUT_QUIESCENT; // R10 R12
			endcase
		end
	end

	// apb decode and read mux
	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pready && pwrite && !pslverr;
	assign mapped    = (paddr == ADDR_START_WAIT) || (paddr == ADDR_FAULT_REQ) ||
		(paddr == ADDR_PULSE_WIDTH) || (paddr == ADDR_STATUS);

	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (paddr)
			ADDR_START_WAIT:  rd_data[START_W-1:0] = start_wait_q;
			ADDR_FAULT_REQ:   rd_data[SHORT_W-1:0] = fault_req_q;
			ADDR_PULSE_WIDTH: rd_data[SHORT_W-1:0] = pulse_q;
			ADDR_STATUS: begin
				rd_data[STAT_PWR_LSB +: 3] = pwr_q;
				rd_data[STAT_ST_LSB +: 3]  = st_q;
				rd_data[STAT_OUT_LSB +: 3] = out_mode;
				rd_data[STAT_DRV_BIT]      = !fault_pin_oe_b;
			end
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// apb answer: no wait states, error on unmapped address
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= apb_setup;
			pslverr <= apb_setup && !mapped;
			prdata  <= (apb_setup && !pwrite) ? rd_data : 32'h0000_0000;
		end
	end

	// timing configuration in 50 us steps; zero is held as one step
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			start_wait_q <= START_WAIT_RST;
			fault_req_q  <= FAULT_REQ_RST;
			pulse_q      <= PULSE_RST;
		end else if (apb_write) begin
			if (paddr == ADDR_START_WAIT) begin
				start_wait_q <= (pwdata[START_W-1:0] == '0) ? START_W'(1) : pwdata[START_W-1:0]; // R21 R23
			end
			if (paddr == ADDR_FAULT_REQ) begin
				fault_req_q <= (pwdata[SHORT_W-1:0] == '0) ? SHORT_W'(1) : pwdata[SHORT_W-1:0]; // R22 R23
			end
			if (paddr == ADDR_PULSE_WIDTH) begin
				pulse_q <= (pwdata[SHORT_W-1:0] == '0) ? SHORT_W'(1) : pwdata[SHORT_W-1:0]; // R23
			end
		end
	end

	// checks on sequencing
	a_start_entry: assert property (st_q == ST_IDLE && !line_high && fault_pin_oe_b && own_q == 3'h0
		&& !psel && pwr_on |=> st_q == ST_START) else $error("start request missed"); // R1
	a_start_blocked: assert property (st_q == ST_IDLE && psel |=> st_q == ST_IDLE)
		else $error("start taken during transaction"); // R14
	a_field_restart: assert property (st_q == ST_START && field_over && !abort |=> tick_cnt_q == '0)
		else $error("start counter not cleared"); // R2
	a_wait_done: assert property (st_q == ST_START && !field_over && !abort && tick_cnt_q >= start_wait_q
		|=> st_q == ST_CHECK ##1 (out_mode == OUT_CHECK_LOW || abort || !pwr_on))
		else $error("check entry wrong"); // R3
	a_check_level: assert property (st_q == ST_CHECK && pwr_on && !abort
		|=> out_mode == ($past(shown_hi_q) ? OUT_CHECK_HIGH : OUT_CHECK_LOW))
		else $error("check level wrong"); // R4
	a_check_delay: assert property (st_q == ST_CHECK && !abort && shown_hi_q != line_high && dly_q < CHECK_LAST
		|=> shown_hi_q == $past(shown_hi_q)) else $error("check level moved early"); // R5
	a_check_hold: assert property (st_q == ST_CHECK && !line_high && !abort |=> st_q == ST_CHECK)
		else $error("check left while line low"); // R6
	a_request_exit: assert property (st_q == ST_CHECK && line_high && !abort
		&& tick_cnt_q >= START_W'(fault_req_q) |=> st_q == ST_POS) else $error("fault test not entered"); // R7
	a_stim_pull: assert property ((st_q == ST_POS || st_q == ST_NEG) && out_over |=> !fault_pin_oe_b)
		else $error("fault line not pulled"); // R9
	a_pulse_step: assert property (st_q == ST_POS && !abort && tick_cnt_q >= START_W'(pulse_q)
		|=> st_q == ST_GAP ##1 (fault_pin_oe_b || abort)) else $error("positive pulse not ended"); // R10
	a_settle_exit: assert property (st_q == ST_SETTLE && dly_q == SETTLE_LAST && !abort |=> st_q == ST_IDLE)
		else $error("settle exit wrong"); // R12
	a_abort_idle: assert property (st_q != ST_IDLE && (psel || !pwr_on) |=> st_q == ST_IDLE)
		else $error("self-test not abandoned"); // R13
	a_lock_enter: assert property (pwr_q == PWR_LOCKWAIT && !lock_low && por_low && pwr_cnt_q == EN_LAST
		|=> pwr_q == PWR_LOCKED ##1 (out_mode == OUT_GROUND || pwr_q == PWR_OFF))
		else $error("lockout not entered"); // R18
	a_unlock: assert property (pwr_q == PWR_LOCKED && lock_up && por_low |=> pwr_q == PWR_UNLOCK)
		else $error("lockout exit not started"); // R19
	a_por_hiz: assert property (!por_low |=> pwr_q == PWR_OFF ##1 out_mode == OUT_HIZ)
		else $error("output not high impedance"); // R16 R20

	c_full_test: cover property (st_q == ST_SETTLE && dly_q == SETTLE_LAST);
	c_txn_abort: cover property (st_q == ST_CHECK && psel);
	c_lockout: cover property (pwr_q == PWR_UNLOCK && pwr_cnt_q == DIS_LAST);
	c_recover: cover property (pwr_q == PWR_LOCKWAIT && lock_low);

endmodule : ssu_top

/* File: ssu_ctrl_model.sv */
module ssu_ctrl_model
	import ssu_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_b,
	// controller pull request
	input  wire logic       pull_req,
	// device side of the fault line
	input  wire logic       fault_pin_o,
	input  wire logic       fault_pin_oe_b,
	input  wire logic [2:0] out_mode,
	// levels seen by the device
	output logic            fault_pin_i,
	output logic            output_over_fault
);
	timeunit 1ns;
	timeprecision 1ps;

	// pulled-up line, low when either party pulls
	assign fault_pin_i = !(pull_req || (!fault_pin_oe_b && !fault_pin_o));

	// output comparator, saturated levels cross the fault threshold
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			output_over_fault <= 1'b0;
		else
			output_over_fault <= (out_mode == OUT_SAT_TOP) || (out_mode == OUT_SAT_BOTTOM);
	end
endmodule : ssu_ctrl_model

/* File: ssu_top_tb.sv */
module ssu_top_tb
	import ssu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 10;
	localparam int LE = 20;
	localparam int LD = 20;
	localparam int PR = 20;

	logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        por_up, por_lo, lk_up, lk_lo, field_over_fault, output_over_fault;
	logic        fault_pin_i, fault_pin_o, fault_pin_oe_b, pull_req, er;
	logic [2:0]  out_mode;
	int          mismatches, tests_run, n, m;

	ssu_top #(.TICK_CYCLES(TK), .LOCK_EN_CYCLES(LE), .LOCK_DIS_CYCLES(LD), .POR_REL_CYCLES(PR)) ssu_top_i (
		.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.supply_above_por_upper(por_up), .supply_above_por_lower(por_lo),
		.supply_above_lockout_upper(lk_up), .supply_above_lockout_lower(lk_lo),
		.field_over_fault(field_over_fault), .output_over_fault(output_over_fault),
		.fault_pin_i(fault_pin_i), .fault_pin_o(fault_pin_o), .fault_pin_oe_b(fault_pin_oe_b), .out_mode(out_mode));

	ssu_ctrl_model ssu_ctrl_model_i (
		.mclk(mclk), .rst_b(rst_b), .pull_req(pull_req), .fault_pin_o(fault_pin_o),
		.fault_pin_oe_b(fault_pin_oe_b), .out_mode(out_mode), .fault_pin_i(fault_pin_i),
		.output_over_fault(output_over_fault));

	// free-running clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task wrap_up;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	// one apb transfer, answer taken at the rising edge where pready is high
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int k;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		// values read right after the edge are those the edge sampled
		@(posedge mclk);
		while (pready !== 1'b1 && k < 50) begin
			@(posedge mclk);
			k++;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			mismatches++;
			$display("unexpected at %0t: no apb answer", $time);
			wrap_up();
		end
		@(posedge mclk);
	endtask : apb

	task rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h00000000);
		chk(rd, exp, what);
	endtask : rd_chk

	// counts cycles until out_mode shows md
	task wait_mode(input logic [2:0] md, input int max);
		n = 0;
		@(negedge mclk);
		while (out_mode !== md && n < max) begin
			@(negedge mclk);
			n++;
		end
		if (n >= max) begin
			mismatches++;
			$display("unexpected at %0t: out_mode wait ran out", $time);
			wrap_up();
		end
		@(posedge mclk);
	endtask : wait_mode

	task look(input logic [31:0] md, input logic ln, input string what);
		@(negedge mclk);
		chk({29'h0, out_mode}, md, what);
		chk({31'h0, fault_pin_oe_b}, {31'h0, ln}, what);
		@(posedge mclk);
	endtask : look

	task t_power;
		por_lo <= 1'b1;
		por_up <= 1'b1;
		lk_lo <= 1'b1;
		repeat (PR + 40) @(posedge mclk);
		look(OUT_HIZ, 1'b1, "hiz before upper lockout");
		lk_up <= 1'b1;
		wait_mode(OUT_FOLLOW, 200);
		chk(n >= LD - 2 && n <= LD + 8, 1, "disable delay");
	endtask : t_power

	task t_regs;
		rd_chk(ADDR_START_WAIT, 32'(START_WAIT_RST), "start wait reset");
		rd_chk(ADDR_FAULT_REQ, 32'(FAULT_REQ_RST), "request reset");
		rd_chk(ADDR_PULSE_WIDTH, 32'(PULSE_RST), "pulse reset");
		rd_chk(12'h010, 32'h00000000, "unmapped read");
		chk(er, 1, "unmapped error");
		apb(1'b1, ADDR_START_WAIT, 32'h00000FA0);
		rd_chk(ADDR_START_WAIT, 32'h00000FA0, "start wait max");
		apb(1'b1, ADDR_FAULT_REQ, 32'h000000C8);
		rd_chk(ADDR_FAULT_REQ, 32'h000000C8, "request max");
		apb(1'b1, ADDR_PULSE_WIDTH, 32'h00000000);
		rd_chk(ADDR_PULSE_WIDTH, 32'h00000001, "zero stores one");
		apb(1'b1, ADDR_START_WAIT, 32'h00000002);
		apb(1'b1, ADDR_FAULT_REQ, 32'h00000078);
		apb(1'b1, ADDR_PULSE_WIDTH, 32'h00000002);
	endtask : t_regs

	task t_seq;
		pull_req <= 1'b1;
		repeat (12) @(posedge mclk);
		field_over_fault <= 1'b1;
		repeat (3) @(posedge mclk);
		field_over_fault <= 1'b0;
		wait_mode(OUT_CHECK_LOW, 200);
		chk(n + 15 >= 12 + 2 * TK && n + 15 <= 60, 1, "start wait restart");
		repeat (300) @(posedge mclk);
		look(OUT_CHECK_LOW, 1'b1, "check holds low");
		pull_req <= 1'b0;
		wait_mode(OUT_CHECK_HIGH, 1100);
		chk(n >= CHECK_DLY_CYC - 2 && n <= CHECK_DLY_CYC + 8, 1, "check delay");
		m = n;
		wait_mode(OUT_SAT_TOP, 400);
		chk(m + n >= 120 * TK - 4 && m + n <= 120 * TK + 15, 1, "request time");
		repeat (6) @(posedge mclk);
		look(OUT_SAT_TOP, 1'b0, "positive pull");
		wait_mode(OUT_QUIESCENT, 100);
		chk(n + 7 >= 2 * TK - 2 && n + 7 <= 2 * TK + 6, 1, "positive width");
		repeat (6) @(posedge mclk);
		look(OUT_QUIESCENT, 1'b1, "gap release");
		wait_mode(OUT_SAT_BOTTOM, 100);
		chk(n + 7 >= 2 * TK - 2 && n + 7 <= 2 * TK + 6, 1, "gap width");
		repeat (6) @(posedge mclk);
		look(OUT_SAT_BOTTOM, 1'b0, "negative pull");
		wait_mode(OUT_QUIESCENT, 100);
		chk(n + 7 >= 2 * TK - 2 && n + 7 <= 2 * TK + 6, 1, "negative width");
		wait_mode(OUT_FOLLOW, 2000);
		chk(n >= SETTLE_CYC - 2 && n <= SETTLE_CYC + 6, 1, "settle time");
		look(OUT_FOLLOW, 1'b1, "normal again");
	endtask : t_seq

	task t_abort;
		pull_req <= 1'b1;
		repeat (8) @(posedge mclk);
		// line released with the access, so no new test starts after the access ends this one
		pull_req <= 1'b0;
		apb(1'b0, ADDR_STATUS, 32'h00000000);
		repeat (60) @(posedge mclk);
		look(OUT_FOLLOW, 1'b1, "abandoned on access");
		apb(1'b0, ADDR_STATUS, 32'h00000000);
		chk({29'h0, rd[6:4]}, 32'h00000000, "idle after access");
		chk({29'h0, rd[2:0]}, 32'(PWR_ON), "supply on after access");
		chk({29'h0, rd[10:8]}, 32'(OUT_FOLLOW), "status output mode");
	endtask : t_abort

	task t_lock;
		pull_req <= 1'b1;
		wait_mode(OUT_CHECK_LOW, 200);
		pull_req <= 1'b0;
		lk_lo <= 1'b0;
		lk_up <= 1'b0;
		repeat (6) @(posedge mclk);
		look(OUT_FOLLOW, 1'b1, "test left on low supply");
		wait_mode(OUT_GROUND, 200);
		chk(n + 7 >= LE - 2 && n + 7 <= LE + 8, 1, "enable delay");
		lk_lo <= 1'b1;
		lk_up <= 1'b1;
		wait_mode(OUT_FOLLOW, 200);
		chk(n >= LD - 2 && n <= LD + 8, 1, "leave lockout");
		lk_lo <= 1'b0;
		repeat (10) @(posedge mclk);
		lk_lo <= 1'b1;
		repeat (40) @(posedge mclk);
		look(OUT_FOLLOW, 1'b1, "short dip ignored");
	endtask : t_lock

	task t_down;
		lk_lo <= 1'b0;
		lk_up <= 1'b0;
		repeat (5) @(posedge mclk);
		por_lo <= 1'b0;
		por_up <= 1'b0;
		wait_mode(OUT_HIZ, 100);
		chk(n <= 8, 1, "direct to hiz");
		{por_lo, por_up, lk_lo, lk_up} <= 4'hF;
		wait_mode(OUT_FOLLOW, 300);
		chk(n >= PR + LD - 2 && n <= PR + LD + 12, 1, "release then wake");
	endtask : t_down

	// main sequence
	initial begin
		{rst_b, psel, penable, pwrite, pull_req, field_over_fault} = 6'h00;
		{por_up, por_lo, lk_up, lk_lo} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		mismatches = 0;
		tests_run = 0;
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		look(OUT_HIZ, 1'b1, "hiz after reset");
		t_power();
		t_regs();
		t_seq();
		t_abort();
		t_lock();
		t_down();
		wrap_up();
	end
endmodule : ssu_top_tb
